// file: hdl/phc_consts.vh
// constants for the pll holdover control block
`ifndef PHC_CONSTS_VH
`define PHC_CONSTS_VH
// How it works
// - holdover holds the charge pump output in high impedance.
// - no holdover source works unless both holdover enable bits are set.
// - external control bit 0 picks automatic holdover, 1 picks the pin.
// - manual mode enters holdover on the alignment pin falling edge.
// - exit waits for pin high and the next reference edge.
// - without reference edges the charge pump stays high impedance until holdover is disabled.
// - feedback B counter resets on the exit edge; prescaler untouched.
// - automatic mode enters holdover when the sensed lock pin is low.
// - comparator disabled means lock pin is sensed as always high.
// - after exit, re-entry waits until the lock pin recharges high.
// - only the selected reference's edges end holdover, unless an enable bit is cleared.
// - lock counter code sets consecutive good cycles; 00 means five.
// - digital lock detector runs only while its disable bit is 0.
// - window bit 0 selects the high range lock window.
// - pin select 000100 puts current source lock detect on the pin.
// - lock holds until one cycle exceeds the wider unlock threshold.
// - current source charges only while lock flag true, else discharges.

// register indices, byte address is four times the index
`define PHC_IDX_LOCK_CFG 10'h018
`define PHC_IDX_LOCK_PIN 10'h01a
`define PHC_IDX_MON_PIN 10'h01b
`define PHC_IDX_REF_SEL 10'h01c
`define PHC_IDX_HOLD_CTRL 10'h01d
`define PHC_IDX_STATUS 10'h01f

// reset values
`define PHC_RST_LOCK_CFG 8'h00
`define PHC_RST_LOCK_PIN 8'h00
`define PHC_RST_MON_PIN 8'h00
`define PHC_RST_REF_SEL 8'h00
`define PHC_RST_HOLD_CTRL 8'h00

// holdover control fields
`define PHC_HO_EN_A 0
`define PHC_HO_EXT 1
`define PHC_HO_EN_B 2
`define PHC_HO_CMP_EN 3

// lock detect config fields
`define PHC_LD_DIS 3
`define PHC_LD_WIN 4
`define PHC_LD_CNT_LO 5
`define PHC_LD_CNT_HI 6
`define PHC_LD_CNT_CODE0 8'd5

// lock pin select field
`define PHC_LPS_HI 5
`define PHC_LPS_CS_MODE 6'h04

// reference select fields
`define PHC_REF_CHOICE 5
`define PHC_REF_USE_PIN 6

// status fields
`define PHC_ST_DLF 0
`define PHC_ST_HOLD 4
`define PHC_ST_SENSED 5
`define PHC_ST_BLOCK 7

`endif

// file: hdl/phc_sync.v
// two flop synchroniser, one bit per lane
`timescale 1ns/1ps
`default_nettype none
module phc_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// lanes
	input wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] safe_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= INIT;
			safe_reg <= INIT;
		end else begin
			meta_reg <= d_in;
			safe_reg <= meta_reg;
		end
	end

	assign q_out = safe_reg;
endmodule
`default_nettype wire

// file: hdl/phc_lock_detect.v
// digital lock detector with programmable consecutive count
`timescale 1ns/1ps
`default_nettype none
`include "phc_consts.vh"
module phc_lock_detect #(
	parameter DW = 8,
	parameter [DW-1:0] LOCK_THR_HI = 8'h20,
	parameter [DW-1:0] UNLOCK_THR_HI = 8'h40,
	parameter [DW-1:0] LOCK_THR_LO = 8'h08,
	parameter [DW-1:0] UNLOCK_THR_LO = 8'h10,
	parameter [7:0] CNT_CODE1 = 8'd16,
	parameter [7:0] CNT_CODE2 = 8'd64,
	parameter [7:0] CNT_CODE3 = 8'd255
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// configuration
	input wire enable,
	input wire window_lo,
	input wire [1:0] cnt_code,
	// phase measurement
	input wire pfd_cycle,
	input wire [DW-1:0] phase_diff,
	// result
	output reg lock_flag
);
	reg [7:0] good_reg;
	reg [7:0] need;
	wire [DW-1:0] lock_thr;
	wire [DW-1:0] unlock_thr;

	// window bit low picks the high range
	assign lock_thr = window_lo ? LOCK_THR_LO : LOCK_THR_HI;
	assign unlock_thr = window_lo ? UNLOCK_THR_LO : UNLOCK_THR_HI;

	always @* begin
		case (cnt_code)
			2'b00: need = `PHC_LD_CNT_CODE0;
			2'b01: need = CNT_CODE1;
			2'b10: need = CNT_CODE2;
			default: need = CNT_CODE3;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			good_reg <= 8'h00;
			lock_flag <= 1'b0;
		end else if (!enable) begin
			good_reg <= 8'h00;
			lock_flag <= 1'b0;
		end else if (pfd_cycle) begin
			if (lock_flag) begin
				if (phase_diff > unlock_thr) begin
					lock_flag <= 1'b0;
					good_reg <= 8'h00;
				end
			end else if (phase_diff < lock_thr) begin
				if (good_reg + 8'h01 >= need) begin
					lock_flag <= 1'b1;
				end
				good_reg <= good_reg + 8'h01;
			end else begin
				good_reg <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/phc_holdover.v
// pll holdover control with apb register file
`timescale 1ns/1ps
`default_nettype none
`include "phc_consts.vh"
module phc_holdover #(
	parameter DW = 8
) (
	// clock and reset
	input wire pclk,
	input wire presetn,

	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,

	// reference path edges at the detector
	input wire primary_ref_input,
	input wire secondary_ref_input,
	input wire reference_choice_pin,

	// phase measurement for lock detect
	input wire pfd_cycle,
	input wire [DW-1:0] phase_diff,

	// alignment pin, active low
	input wire align_pin_n,

	// lock indicator pin and its comparator
	input wire lock_cmp_in,
	output reg lock_indicator_pin_out,
	output reg lock_indicator_pin_oe_n,
	output reg lock_src_on,

	// charge pump and divider control
	output wire charge_pump_hiz,
	output reg b_counter_reset,
	output wire digital_lock_flag
);

	//----------------------------------------
	// register file
	//----------------------------------------
	reg [7:0] lock_detect_config_reg;
	reg [7:0] lock_pin_select_reg;
	reg [7:0] ref_monitor_pin_select_reg;
	reg [7:0] reference_select_ctrl_reg;
	reg [7:0] holdover_ctrl_reg;

	wire [9:0] idx;
	wire hit;
	wire wr_en;
	wire rd_setup;
	reg [7:0] rd_mux;

	assign idx = paddr[11:2];
	assign hit = (idx == `PHC_IDX_LOCK_CFG) ||
		(idx == `PHC_IDX_LOCK_PIN) ||
		(idx == `PHC_IDX_MON_PIN) ||
		(idx == `PHC_IDX_REF_SEL) ||
		(idx == `PHC_IDX_HOLD_CTRL) ||
		(idx == `PHC_IDX_STATUS);

	// zero wait state slave
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_en = psel & penable & pwrite & hit;
	assign rd_setup = psel & ~penable & ~pwrite;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_detect_config_reg <= `PHC_RST_LOCK_CFG;
			lock_pin_select_reg <= `PHC_RST_LOCK_PIN;
			ref_monitor_pin_select_reg <= `PHC_RST_MON_PIN;
			reference_select_ctrl_reg <= `PHC_RST_REF_SEL;
			holdover_ctrl_reg <= `PHC_RST_HOLD_CTRL;
		end else if (wr_en) begin
			case (idx)
				`PHC_IDX_LOCK_CFG: begin
					lock_detect_config_reg <= pwdata[7:0];
				end
				`PHC_IDX_LOCK_PIN: begin
					lock_pin_select_reg <= pwdata[7:0];
				end
				`PHC_IDX_MON_PIN: begin
					ref_monitor_pin_select_reg <= pwdata[7:0];
				end
				`PHC_IDX_REF_SEL: begin
					reference_select_ctrl_reg <= pwdata[7:0];
				end
				`PHC_IDX_HOLD_CTRL: begin
					holdover_ctrl_reg <= pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	//----------------------------------------
	// pin synchronisers
	//----------------------------------------
	wire align_s;
	wire cmp_s;
	reg align_prev_reg;

	phc_sync #(
		.W(2),
		.INIT(2'b11)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d_in({align_pin_n, lock_cmp_in}),
		.q_out({align_s, cmp_s})
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			align_prev_reg <= 1'b1;
		end else begin
			align_prev_reg <= align_s;
		end
	end

	//----------------------------------------
	// reference selection
	//----------------------------------------
	wire use_second;
	wire ref_edge;

	assign use_second = reference_select_ctrl_reg[`PHC_REF_USE_PIN] ?
		reference_choice_pin : reference_select_ctrl_reg[`PHC_REF_CHOICE];
	// only the active reference can end holdover
	assign ref_edge = use_second ? secondary_ref_input : primary_ref_input;

	//----------------------------------------
	// digital lock detector
	//----------------------------------------
	wire dlf;

	phc_lock_detect #(
		.DW(DW)
	) u_lock (
		.pclk(pclk),
		.presetn(presetn),
		.enable(~lock_detect_config_reg[`PHC_LD_DIS]),
		.window_lo(lock_detect_config_reg[`PHC_LD_WIN]),
		.cnt_code(lock_detect_config_reg[`PHC_LD_CNT_HI:`PHC_LD_CNT_LO]),
		.pfd_cycle(pfd_cycle),
		.phase_diff(phase_diff),
		.lock_flag(dlf)
	);

	assign digital_lock_flag = dlf;

	//----------------------------------------
	// lock indicator pin drive
	//----------------------------------------
	wire cs_mode;

	assign cs_mode = (lock_pin_select_reg[`PHC_LPS_HI:0] == `PHC_LPS_CS_MODE);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_src_on <= 1'b0;
			lock_indicator_pin_out <= 1'b0;
			lock_indicator_pin_oe_n <= 1'b0;
		end else if (cs_mode) begin
			// source on while locked, short to ground otherwise
			lock_src_on <= dlf;
			lock_indicator_pin_out <= 1'b0;
			lock_indicator_pin_oe_n <= dlf;
		end else begin
			lock_src_on <= 1'b0;
			lock_indicator_pin_out <= dlf;
			lock_indicator_pin_oe_n <= 1'b0;
		end
	end

	//----------------------------------------
	// holdover state machine
	//----------------------------------------
	localparam [1:0] ST_RUN = 2'd0;
	localparam [1:0] ST_HOLD = 2'd1;
	localparam [1:0] ST_BLOCK = 2'd2;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg b_reset_next;
	wire ho_enable;
	wire ext_mode;
	wire cmp_en;
	wire sensed_ld;
	wire align_fall;
	wire enter_man;
	wire enter_auto;
	wire enter_now;

	assign ho_enable = holdover_ctrl_reg[`PHC_HO_EN_A] &
		holdover_ctrl_reg[`PHC_HO_EN_B];
	assign ext_mode = holdover_ctrl_reg[`PHC_HO_EXT];
	assign cmp_en = holdover_ctrl_reg[`PHC_HO_CMP_EN];
	assign sensed_ld = cmp_en ? cmp_s : 1'b1;
	assign align_fall = align_prev_reg & ~align_s;
	assign enter_man = ho_enable & ext_mode & align_fall;
	assign enter_auto = ho_enable & ~ext_mode & ~sensed_ld;
	assign enter_now = (state_reg == ST_RUN) & (enter_man | enter_auto);

	always @* begin
		state_next = state_reg;
		b_reset_next = 1'b0;
		case (state_reg)
			ST_RUN: begin
				if (enter_man | enter_auto) begin
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!ho_enable) begin
					state_next = ST_RUN;
				end else if (ref_edge && (!ext_mode || align_s)) begin
					b_reset_next = 1'b1;
					if (ext_mode) begin
						state_next = ST_RUN;
					end else begin
						state_next = ST_BLOCK;
					end
				end
			end
			ST_BLOCK: begin
				if (!ho_enable || ext_mode || sensed_ld) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_RUN;
			b_counter_reset <= 1'b0;
		end else begin
			state_reg <= state_next;
			b_counter_reset <= b_reset_next;
		end
	end

	// high impedance from the entry cycle until the exit edge
	assign charge_pump_hiz = (state_reg == ST_HOLD) | enter_now;

	//----------------------------------------
	// read back
	//----------------------------------------
	wire [7:0] status_val;

	assign status_val = {
		(state_reg == ST_BLOCK),
		1'b0,
		sensed_ld,
		(state_reg == ST_HOLD),
		3'b000,
		dlf
	};

	always @* begin
		case (idx)
			`PHC_IDX_LOCK_CFG: rd_mux = lock_detect_config_reg;
			`PHC_IDX_LOCK_PIN: rd_mux = lock_pin_select_reg;
			`PHC_IDX_MON_PIN: rd_mux = ref_monitor_pin_select_reg;
			`PHC_IDX_REF_SEL: rd_mux = reference_select_ctrl_reg;
			`PHC_IDX_HOLD_CTRL: rd_mux = holdover_ctrl_reg;
			`PHC_IDX_STATUS: rd_mux = status_val;
			default: rd_mux = 8'h00;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= {24'h00_0000, rd_mux};
		end
	end

endmodule
`default_nettype wire

// file: tb/phc_cap_model.sv
// lock pin capacitor and comparator model at the far side of the lock pin
`timescale 1ns/1ps
`default_nettype none
module phc_cap_model #(
	parameter int CHG = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// lock pin drive
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic src_on,
	// comparator
	output logic cmp_out
);
	int lvl;
	// driven pin sets level, current source charges, else capacitor holds
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lvl <= 0;
		else if (!pin_oe_n)
			lvl <= pin_out ? CHG : 0;
		else if (src_on && lvl < CHG)
			lvl <= lvl + 1;
	end
	assign cmp_out = (lvl >= CHG);
endmodule
`default_nettype wire

// file: tb/phc_holdover_assertions.sv
// checker for the holdover block ports
`timescale 1ns/1ps
`default_nettype none
`include "phc_consts.vh"
module phc_holdover_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// pins
	input wire logic primary_ref_input,
	input wire logic secondary_ref_input,
	input wire logic pfd_cycle,
	input wire logic align_pin_n,
	input wire logic lock_indicator_pin_oe_n,
	input wire logic lock_src_on,
	input wire logic charge_pump_hiz,
	input wire logic b_counter_reset,
	input wire logic digital_lock_flag
);
	logic [3:0] hc;
	logic wr;
	logic mapped;
	assign wr = psel && penable && pwrite;
	assign mapped = paddr[11:2] inside {`PHC_IDX_LOCK_CFG, `PHC_IDX_LOCK_PIN,
		`PHC_IDX_MON_PIN, `PHC_IDX_REF_SEL, `PHC_IDX_HOLD_CTRL, `PHC_IDX_STATUS};
	// shadow of the holdover control bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hc <= 4'h0;
		else if (wr && pready && paddr[11:2] == `PHC_IDX_HOLD_CTRL)
			hc <= pwdata[3:0];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence exit_seq;
		b_counter_reset && !charge_pump_hiz ##1 !b_counter_reset;
	endsequence
	sequence man_fall;
		hc == 4'h7 && $fell(align_pin_n);
	endsequence
	apb_ready_a: assert property (pready && prdata[31:8] == 24'h0)
		else $error("apb ready or upper read data wrong");
	unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error does not follow address map");
	manual_entry_a: assert property (man_fall |-> ##[1:4] charge_pump_hiz)
		else $error("alignment pin fall did not enter holdover");
	disabled_hold_a: assert property (!$past(hc[0] && hc[2]) &&
		!(hc[0] && hc[2]) |-> !charge_pump_hiz)
		else $error("holdover while disabled");
	exit_ref_a: assert property ($rose(b_counter_reset) |->
		$past(primary_ref_input || secondary_ref_input) && $past(charge_pump_hiz))
		else $error("holdover exit without reference edge");
	bcr_pulse_a: assert property (b_counter_reset |-> exit_seq)
		else $error("counter reset not one cycle at exit");
	hiz_stays_a: assert property (charge_pump_hiz && !primary_ref_input &&
		!secondary_ref_input && !wr && hc[0] && hc[2] |=> charge_pump_hiz)
		else $error("holdover left without reference edge");
	src_drain_a: assert property (lock_src_on |-> lock_indicator_pin_oe_n)
		else $error("lock pin charged and discharged at once");
	dlf_pfd_a: assert property ($rose(digital_lock_flag) |-> $past(pfd_cycle))
		else $error("lock flag rose without detector cycle");
	exit_c: cover property (exit_seq);
endmodule
bind phc_holdover phc_holdover_chk i_phc_holdover_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .prdata(prdata),
	.primary_ref_input(primary_ref_input), .secondary_ref_input(secondary_ref_input),
	.pfd_cycle(pfd_cycle), .align_pin_n(align_pin_n),
	.lock_indicator_pin_oe_n(lock_indicator_pin_oe_n), .lock_src_on(lock_src_on),
	.charge_pump_hiz(charge_pump_hiz), .b_counter_reset(b_counter_reset),
	.digital_lock_flag(digital_lock_flag));
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the holdover block
`timescale 1ns/1ps
`default_nettype none
`include "phc_consts.vh"
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic pri = 0, sec = 0, pfdc = 0, align = 1, rsel = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [7:0] pd = 0, v;
	logic [9:0] idx_t[5] = '{`PHC_IDX_LOCK_CFG, `PHC_IDX_LOCK_PIN, `PHC_IDX_MON_PIN,
		`PHC_IDX_REF_SEL, `PHC_IDX_HOLD_CTRL};
	logic [7:0] cfg_t[4] = '{8'h00, 8'h10, 8'h10, 8'h08};
	logic [7:0] dif_t[4] = '{8'h00, 8'h1f, 8'h07, 8'h00};
	wire pready, pslverr, cmp, lo, oen, src, hiz, bcr, dlf;
	wire [31:0] prdata;
	int error_cnt = 0, total_checks = 0, s;
	always #5 pclk = ~pclk;
	phc_holdover #(.DW(8)) i_phc_holdover (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .primary_ref_input(pri),
		.secondary_ref_input(sec), .reference_choice_pin(rsel), .pfd_cycle(pfdc),
		.phase_diff(pd), .align_pin_n(align), .lock_cmp_in(cmp),
		.lock_indicator_pin_out(lo), .lock_indicator_pin_oe_n(oen), .lock_src_on(src),
		.charge_pump_hiz(hiz), .b_counter_reset(bcr), .digital_lock_flag(dlf));
	phc_cap_model #(.CHG(8)) i_phc_cap_model (.pclk(pclk), .presetn(presetn),
		.pin_out(lo), .pin_oe_n(oen), .src_on(src), .cmp_out(cmp));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task conclude;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			conclude();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task phase_freq_detector(input logic [7:0] d);
		@(posedge pclk);
		pfdc <= 1;
		pd <= d;
		@(posedge pclk);
		pfdc <= 0;
	endtask
	task rpulse(input logic second);
		@(posedge pclk);
		pri <= !second;
		sec <= second;
		@(posedge pclk);
		pri <= 0;
		sec <= 0;
	endtask
	function automatic logic lock_exp(logic [7:0] c, logic [7:0] d);
		return !c[3] && d < (c[4] ? 8'h08 : 8'h20);
	endfunction
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		s = $urandom(90433);
		repeat (16) @(posedge pclk);
		presetn <= 1;
		cyc(3);
		foreach (idx_t[i]) begin
			apb(0, idx_t[i], 8'h00);
			chk(rd, 32'h0);
			chk(er, 1'b0);
			v = $urandom;
			apb(1, idx_t[i], v);
			apb(0, idx_t[i], 8'h00);
			chk(rd, {24'h0, v});
			apb(1, idx_t[i], 8'h00);
		end
		apb(0, 10'h020, 8'h00);
		chk(rd, 32'h0);
		chk(er, 1'b1);
		dif_t[0] = $urandom % 32;
		for (int i = 0; i < 4; i++) begin
			apb(1, `PHC_IDX_LOCK_CFG, 8'h08);
			apb(1, `PHC_IDX_LOCK_CFG, cfg_t[i]);
			repeat (4) phase_freq_detector(dif_t[i]);
			cyc(1);
			chk(dlf, 1'b0);
			phase_freq_detector(dif_t[i]);
			cyc(1);
			chk(dlf, lock_exp(cfg_t[i], dif_t[i]));
			cyc(1);
			chk({lo, oen, src}, {lock_exp(cfg_t[i], dif_t[i]), 2'b00});
			if (lock_exp(cfg_t[i], dif_t[i])) begin
				phase_freq_detector(cfg_t[i][4] ? 8'h10 : 8'h40);
				cyc(1);
				chk(dlf, 1'b1);
				phase_freq_detector(cfg_t[i][4] ? 8'h11 : 8'h41);
				cyc(1);
				chk(dlf, 1'b0);
			end
		end
		// count code 01 needs sixteen good cycles
		apb(1, `PHC_IDX_LOCK_CFG, 8'h20);
		repeat (15) phase_freq_detector(8'h00);
		cyc(1);
		chk(dlf, 1'b0);
		phase_freq_detector(8'h00);
		cyc(1);
		chk(dlf, 1'b1);
		apb(1, `PHC_IDX_LOCK_CFG, 8'h08);
		// manual holdover, secondary reference selected, dividers assumed to ignore the pin
		apb(1, `PHC_IDX_REF_SEL, 8'h20);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h03);
		@(posedge pclk) align <= 0;
		cyc(5);
		chk(hiz, 1'b0);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h07);
		cyc(5);
		chk(hiz, 1'b0);
		@(posedge pclk) align <= 1;
		cyc(4);
		@(posedge pclk) align <= 0;
		cyc(5);
		chk(hiz, 1'b1);
		apb(0, `PHC_IDX_STATUS, 8'h00);
		chk(rd[`PHC_ST_HOLD], 1'b1);
		@(posedge pclk) align <= 1;
		cyc(4);
		rpulse(0);
		cyc(20);
		chk(hiz, 1'b1);
		// choice pin now picks the reference, low selects the primary
		apb(1, `PHC_IDX_REF_SEL, 8'h40);
		rpulse(1);
		cyc(2);
		chk(hiz, 1'b1);
		rsel <= 1;
		rpulse(1);
		cyc(1);
		chk(bcr, 1'b1);
		chk(hiz, 1'b0);
		cyc(1);
		chk(bcr, 1'b0);
		// automatic holdover on the current source lock pin
		apb(1, `PHC_IDX_REF_SEL, 8'h00);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h00);
		apb(1, `PHC_IDX_LOCK_CFG, 8'h00);
		apb(1, `PHC_IDX_LOCK_PIN, 8'h04);
		repeat (5) phase_freq_detector(8'h01);
		cyc(20);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h0d);
		cyc(3);
		chk(hiz, 1'b0);
		phase_freq_detector(8'h50);
		cyc(16);
		chk(hiz, 1'b1);
		chk({lo, oen, src}, 3'b000);
		rpulse(0);
		cyc(1);
		chk(bcr, 1'b1);
		cyc(5);
		chk(hiz, 1'b0);
		repeat (5) phase_freq_detector(8'h01);
		cyc(20);
		chk(hiz, 1'b0);
		chk({lo, oen, src}, 3'b011);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h05);
		phase_freq_detector(8'h50);
		cyc(16);
		chk(hiz, 1'b0);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h0d);
		cyc(3);
		chk(hiz, 1'b1);
		apb(1, `PHC_IDX_HOLD_CTRL, 8'h00);
		cyc(2);
		chk(hiz, 1'b0);
		chk(bcr, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
